// ### bench/dsf_chk.sv
// Port-level checks for the serial status frame block
`timescale 1ns/1ps
module dsf_chk (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic csn_b,
   input wire logic sdi,
   input wire logic [dsf_pkg::NUM_LOADS-1:0] open_circuit_fault,
   input wire logic [dsf_pkg::NUM_LOADS-1:0] over_current_fault,
   input wire logic supply_low_det,
   input wire logic supply_high_det,
   input wire logic thermal_sd_det,
   input wire logic thermal_warn_det,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic fault_summary,
   input wire logic [dsf_pkg::NUM_CTRL-1:0][7:0] ctrl_out
);
   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   logic sclk_r;
   logic sclk_nxt;
   logic bad_cnt;
   logic any_fault;
   // Counts serial clock rises within one frame
   always_comb
   begin
      sclk_nxt = sclk;
      cnt_nxt = cnt_r;
      if (csn_b)
         cnt_nxt = 6'h00;
      else if (sclk && !sclk_r)
         cnt_nxt = cnt_r + 6'h01;
   end
   always_ff @(posedge core_clk)
   begin
      sclk_r <= sclk_nxt;
      cnt_r <= cnt_nxt;
   end
   assign bad_cnt = (cnt_r != 6'h00) && ((cnt_r[2:0] != 3'h0) || (cnt_r < 6'h10));
   assign any_fault = |open_circuit_fault || |over_current_fault || supply_low_det
      || supply_high_det || thermal_sd_det || thermal_warn_det;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   sequence frame_open;
      $fell(csn_b) ##1 (!csn_b && !sclk && $stable(sdi)) [*6];
   endsequence
   sequence pol_close;
      (sclk && $rose(csn_b)) ##1 (sclk && csn_b);
   endsequence
   reset_state_a:
      assert property (disable iff (1'b0) !rst_b |=> !sdo_oe && fault_summary
         && (ctrl_out == '0)) else $error("reset state wrong");
   poll_value_a:
      assert property (frame_open |-> sdo_oe && (sdo == (fault_summary | sdi)))
      else $error("pre-clock output wrong");
   idle_release_a:
      assert property (csn_b [*6] |-> !sdo_oe && !sdo) else $error("output not released");
   fault_latch_a:
      assert property (any_fault [*6] |-> fault_summary) else $error("fault not summed");
   count_error_a:
      assert property (bad_cnt && $rose(csn_b) |-> ##[1:10] fault_summary)
      else $error("bad clock count missed");
   open_polarity_a:
      assert property (sclk && $fell(csn_b) |-> ##[1:400] fault_summary)
      else $error("polarity at select fall missed");
   close_polarity_a:
      assert property (pol_close |-> ##[1:10] fault_summary)
      else $error("polarity at select rise missed");
   ctrl_hold_a:
      assert property ((!csn_b) [*4] |-> $stable(ctrl_out)) else $error("control moved in frame");
   summary_hold_a:
      assert property (csn_b [*8] |-> !$fell(fault_summary)) else $error("summary dropped idle");
endmodule

bind dsf_top dsf_chk chk (
   .core_clk, .rst_b, .sclk, .csn_b, .sdi, .open_circuit_fault, .over_current_fault,
   .supply_low_det, .supply_high_det, .thermal_sd_det, .thermal_warn_det,
   .sdo, .sdo_oe, .fault_summary, .ctrl_out
);

// ### bench/dsf_host.sv
// Host serial master model driving clock, select and data
`timescale 1ns/1ps
module dsf_host (
   output logic sclk,
   output logic csn_b,
   output logic sdi,
   input wire logic sdo
);
   initial
   begin
      sclk = 1'b0;
      csn_b = 1'b1;
      sdi = 1'b0;
   end
   task automatic xfer(input int n, input logic [31:0] tx, input logic [1:0] pol,
      input logic pre_in, output logic [31:0] rx, output logic pre);
      int i;
      rx = '0;
      #7 sclk <= pol[0];
      #40 csn_b <= 1'b0;
      sdi <= pre_in;
      #40 sclk <= 1'b0;
      #80 pre = sdo;
      for (i = n - 1; i >= 0; i--)
      begin
         sdi <= tx[i];
         sclk <= 1'b1;
         #80 sclk <= 1'b0;
         #80 rx[i] = sdo;
      end
      #40 sclk <= pol[1];
      #80 csn_b <= 1'b1;
      #100 sclk <= 1'b0;
      sdi <= ~sdi;
      #200;
   endtask
endmodule

// ### bench/dsf_top_tb.sv
// Self-checking bench for the serial status frame block
`timescale 1ns/1ps
module dsf_top_tb;
   localparam logic [4:0] STAT = dsf_pkg::STAT_ADDR;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [5:0] src = 6'h00;
   logic sclk;
   logic csn_b;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   logic fault_summary;
   logic [3:0][7:0] ctrl_out;
   logic [31:0] rx;
   logic pre;
   wire sdo_w = sdo_oe ? sdo : 1'bz;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int nb [7] = '{12, 16, 16, 16, 16, 16, 8};
   logic [7:0] ad [7] = '{8'h87, 8'hA3, 8'h86, 8'h85, 8'h87, 8'h87, 8'h87};
   logic [1:0] pl [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
   logic [7:0] fx [6] = '{8'h48, 8'h48, 8'h28, 8'h18, 8'h0C, 8'h0A};
   always #10 core_clk = ~core_clk;
   dsf_top dut (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .sclk(sclk),
      .csn_b(csn_b),
      .sdi(sdi),
      .open_circuit_fault({src[0], 7'h00}),
      .over_current_fault({7'h00, src[1]}),
      .supply_low_det(src[2]),
      .supply_high_det(src[3]),
      .thermal_sd_det(src[4]),
      .thermal_warn_det(src[5]),
      .sdo(sdo),
      .sdo_oe(sdo_oe),
      .fault_summary(fault_summary),
      .ctrl_out(ctrl_out)
   );
   dsf_host host (
      .sclk(sclk),
      .csn_b(csn_b),
      .sdi(sdi),
      .sdo(sdo_w)
   );
   function automatic logic [7:0] ab(input logic op, input logic [4:0] a);
      return {op, a, 2'b11};
   endfunction
   task automatic frm(input int n, input logic [15:0] w, input logic [1:0] pol);
      @(posedge core_clk);
      host.xfer(n, {16'h0000, w}, pol, 1'b0, rx, pre);
   endtask
   task automatic poll(input logic v);
      @(posedge core_clk);
      host.xfer(0, 32'h0000_0000, 2'h0, v, rx, pre);
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         num_errors++;
         conclude();
      end
   end
   initial
   begin
      int i;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      poll(1'b0);
      check("reset poll", {7'h00, pre}, 8'h01);
      frm(16, {ab(1'b0, STAT), 8'h00}, 2'h0);
      check("reset status", rx[15:8], 8'h00);
      frm(16, {ab(1'b1, STAT), 8'h00}, 2'h0);
      poll(1'b0);
      check("clear poll", {7'h00, pre}, 8'h00);
      poll(1'b1);
      check("input poll", {7'h00, pre}, 8'h01);
      frm(16, {ab(1'b0, STAT), 8'h00}, 2'h0);
      check("clean status", rx[15:8], 8'h08);
      check("status reply", rx[7:0], 8'h08);
      // Upstream address unmarked, last address byte marked
      @(posedge core_clk);
      host.xfer(32, {8'h01, ab(1'b0, STAT), 16'h0000}, 2'h0, 1'b0, rx, pre);
      check("chain status", rx[31:24], 8'h08);
      check("chain pass", rx[23:16], 8'h01);
      check("chain reply", rx[15:8], 8'h08);
      $display("test status finished");
      for (i = 0; i < 4; i++)
      begin
         frm(16, {ab(1'b1, 5'(i)), 8'hA0 + 8'(i)}, 2'h0);
         check("old value", rx[7:0], 8'h00);
         check("written", ctrl_out[i], 8'hA0 + 8'(i));
         frm(16, {ab(1'b0, 5'(i)), 8'h55}, 2'h0);
         check("read back", rx[7:0], 8'hA0 + 8'(i));
         check("read only", ctrl_out[i], 8'hA0 + 8'(i));
      end
      $display("test control finished");
      for (i = 0; i < 7; i++)
      begin
         frm(nb[i], {ad[i], 8'h3C}, pl[i]);
         check("refused", ctrl_out[1], 8'hA1);
         frm(16, {ab(1'b0, STAT), 8'h00}, 2'h0);
         check("error flag", rx[15:8], 8'h88);
         frm(16, {ab(1'b1, STAT), 8'h00}, 2'h0);
      end
      $display("test errors finished");
      for (i = 0; i < 6; i++)
      begin
         @(posedge core_clk);
         src <= 6'h01 << i;
         repeat (6) @(posedge core_clk);
         src <= 6'h00;
         poll(1'b0);
         check("fault poll", {7'h00, pre}, 8'h01);
         frm(16, {ab(1'b0, STAT), 8'h00}, 2'h0);
         check("fault status", rx[15:8], fx[i]);
         frm(16, {ab(1'b1, STAT), 8'h00}, 2'h0);
      end
      $display("test faults finished");
      conclude();
   end
endmodule

// ### verilog/dsf_link.sv
// Serial-clock shifter: samples on falling edges, presents bits on rising edges
`timescale 1ns/1ps
module dsf_link (
   input wire logic sclk,
   input wire logic sdi,
   dsf_link_if.link lif
);
   logic [dsf_pkg::CNT_W-1:0] cnt_r;
   logic [dsf_pkg::CNT_W-1:0] cnt_nxt;
   logic [7:0] sh_r;
   logic [7:0] sh_nxt;
   logic [7:0] addr_r;
   logic [7:0] addr_nxt;
   logic [7:0] nb;
   logic [7:0] resp;
   logic seen_r;
   logic seen_nxt;
   logic started_r;
   logic out_bit_r;
   logic out_bit_nxt;
   dsf_pkg::dsf_kind_t kind;

   // Falling edge: shift in, catch the marked address byte
   always_comb
   begin
      nb = {sh_r[6:0], sdi};
      kind = dsf_pkg::reg_kind(nb[dsf_pkg::ADDR_MSB:dsf_pkg::ADDR_LSB]);
      resp = dsf_pkg::BYTE_RST;
      if (kind == dsf_pkg::KIND_STAT)
         resp = lif.status_snap;
      else if (kind == dsf_pkg::KIND_CTRL)
         resp = lif.ctrl_img[nb[dsf_pkg::ADDR_LSB+1:dsf_pkg::ADDR_LSB]];
      cnt_nxt = cnt_r;
      if (cnt_r != dsf_pkg::CNT_MAX)
         cnt_nxt = cnt_r + dsf_pkg::CNT_ONE;
      sh_nxt = nb;
      addr_nxt = addr_r;
      seen_nxt = seen_r;
      if ((cnt_r[2:0] == dsf_pkg::BYTE_LAST_BIT) && !seen_r && nb[dsf_pkg::MARK_POS])
      begin
         seen_nxt = 1'b1;
         addr_nxt = nb;
         sh_nxt = resp;
      end
   end

   always_ff @(negedge sclk or posedge lif.link_clear)
   begin
      if (lif.link_clear)
      begin
         cnt_r <= dsf_pkg::CNT_RST;
         sh_r <= dsf_pkg::BYTE_RST;
         addr_r <= dsf_pkg::BYTE_RST;
         seen_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         addr_r <= addr_nxt;
         seen_r <= seen_nxt;
      end
   end

   // Status byte during first eight clocks
   always_comb
   begin
      if (cnt_r[dsf_pkg::CNT_W-1:3] == 7'h00)
         out_bit_nxt = lif.status_snap[dsf_pkg::BYTE_LAST_BIT - cnt_r[2:0]];
      else
         out_bit_nxt = sh_r[7];
   end

   always_ff @(posedge sclk or posedge lif.link_clear)
   begin
      if (lif.link_clear)
      begin
         started_r <= 1'b0;
         out_bit_r <= 1'b0;
      end
      else
      begin
         started_r <= 1'b1;
         out_bit_r <= out_bit_nxt;
      end
   end

   assign lif.started = started_r;
   assign lif.out_bit = out_bit_r;
   assign lif.bit_cnt = cnt_r;
   assign lif.addr_byte = addr_r;
   assign lif.data_byte = sh_r;
   assign lif.addr_seen = seen_r;
endmodule

// ### verilog/dsf_link_if.sv
// Signals passed between the core-side frame logic and the serial-clock shifter
`timescale 1ns/1ps
interface dsf_link_if;
   logic link_clear;
   logic [7:0] status_snap;
   logic [dsf_pkg::NUM_CTRL-1:0][7:0] ctrl_img;
   logic started;
   logic out_bit;
   logic [dsf_pkg::CNT_W-1:0] bit_cnt;
   logic [7:0] addr_byte;
   logic [7:0] data_byte;
   logic addr_seen;

   modport core (
      output link_clear,
      output status_snap,
      output ctrl_img,
      input started,
      input out_bit,
      input bit_cnt,
      input addr_byte,
      input data_byte,
      input addr_seen
   );

   modport link (
      input link_clear,
      input status_snap,
      input ctrl_img,
      output started,
      output out_bit,
      output bit_cnt,
      output addr_byte,
      output data_byte,
      output addr_seen
   );
endinterface

// ### verilog/dsf_pkg.sv
// Shared constants, field positions and register decoding for the serial status frame block
package dsf_pkg;

   // Frame counting
   localparam int CNT_W = 10;
   localparam logic [9:0] CNT_RST = 10'h000;
   localparam logic [9:0] CNT_ONE = 10'h001;
   localparam logic [9:0] CNT_MAX = 10'h3FF;
   localparam logic [9:0] MIN_FRAME_BITS = 10'h010;
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

   // Register store
   localparam int NUM_CTRL = 4;
   localparam int NUM_LOADS = 8;
   localparam logic [4:0] STAT_ADDR = 5'h10;
   localparam logic [4:0] CTRL_COUNT = 5'h04;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic FLAG_RST = 1'b0;
   localparam logic RESET_SEEN_RST = 1'b0;

   // Address byte fields
   localparam int OP_POS = 7;
   localparam int ADDR_MSB = 6;
   localparam int ADDR_LSB = 2;
   localparam int MARK_POS = 1;
   localparam int ONE_POS = 0;

   // Status summary byte fields
   localparam int PROTO_POS = 7;
   localparam int LOAD_POS = 6;
   localparam int SUPPLY_LOW_POS = 5;
   localparam int SUPPLY_HIGH_POS = 4;
   localparam int RESET_SEEN_POS = 3;
   localparam int THERM_SD_POS = 2;
   localparam int THERM_WARN_POS = 1;

   typedef enum logic [1:0] {KIND_NONE, KIND_CTRL, KIND_STAT} dsf_kind_t;

   // Decodes a five-bit register address
   function automatic dsf_kind_t reg_kind(input logic [4:0] addr);
      dsf_kind_t k;
      k = KIND_NONE;
      if (addr == STAT_ADDR)
         k = KIND_STAT;
      else if (addr < CTRL_COUNT)
         k = KIND_CTRL;
      return k;
   endfunction

endpackage

// ### verilog/dsf_top.sv
// Serial slave framing: status summary, fault summary, protocol checks, register access
// What this block does
// - Status summary byte leaves on the output during the first eight clocks.
// - Load fault flag is the OR of all open-circuit and over-current faults.
// - Fault summary bit ORs all status flags plus inverted reset-not-seen flag.
// - Reset-not-seen flag is 0 after reset, so fault summary starts at 1.
// - Protocol fault is status bit 7, visible from the frame after the error.
// - A nonzero clock count not a multiple of eight of at least sixteen is an error.
// - Accessing an address with no register is a protocol error.
// - An address byte whose lowest bit is not 1 is a protocol error.
// - Single slave: a missing final-address marker at bit 1 is an error.
// - Chain: a missing marker in the last address byte is an error.
// - Serial clock high at either chip select edge is a protocol error.
// - Address bits 6..2 select register; operation 1 writes or clears, 0 reads.
// - The addressed register's contents leave while the data byte comes in.
// - Before the first clock rise, output is fault summary ORed with input.
// - Upstream bytes pass through, so status and response bytes arrive reversed.
// - A frame without clocks still shows the fault summary on the output.
// - Input sampled on falling clock edges, output updated on rising edges.
// - Frame acted upon at chip select rise, where the output is released.
// - Operation select is bit 7 of the address byte.
`timescale 1ns/1ps
module dsf_top (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic csn_b,
   input wire logic sdi,
   input wire logic [dsf_pkg::NUM_LOADS-1:0] open_circuit_fault,
   input wire logic [dsf_pkg::NUM_LOADS-1:0] over_current_fault,
   input wire logic supply_low_det,
   input wire logic supply_high_det,
   input wire logic thermal_sd_det,
   input wire logic thermal_warn_det,
   output logic sdo,
   output logic sdo_oe,
   output logic fault_summary,
   output logic [dsf_pkg::NUM_CTRL-1:0][7:0] ctrl_out
);
   localparam int SYNC_W = 9 + 2 * dsf_pkg::NUM_LOADS;

   typedef enum logic {ST_IDLE, ST_FRAME} dsf_state_t;

   dsf_link_if lif ();

   dsf_link u_link (
      .sclk(sclk),
      .sdi(sdi),
      .lif(lif.link)
   );

   // Pin and link-domain levels through two flip-flops
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic csn_s;
   logic sclk_s;
   logic sdi_s;
   logic started_s;
   logic out_bit_s;
   logic supply_low_s;
   logic supply_high_s;
   logic thermal_sd_s;
   logic thermal_warn_s;
   logic [dsf_pkg::NUM_LOADS-1:0] open_s;
   logic [dsf_pkg::NUM_LOADS-1:0] over_s;

   logic [SYNC_W-1:0] sync1_nxt;

   always_comb
   begin
      sync1_nxt = {csn_b, sclk, sdi, lif.started, lif.out_bit, supply_low_det,
                   supply_high_det, thermal_sd_det, thermal_warn_det,
                   open_circuit_fault, over_current_fault};
   end

   always_ff @(posedge core_clk)
   begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync1_r;
   end

   assign {csn_s, sclk_s, sdi_s, started_s, out_bit_s, supply_low_s, supply_high_s,
           thermal_sd_s, thermal_warn_s, open_s, over_s} = sync2_r;

   // Status flags and frame state
   dsf_state_t state_r;
   dsf_state_t state_nxt;
   logic proto_r;
   logic proto_nxt;
   logic load_r;
   logic load_nxt;
   logic ulow_r;
   logic ulow_nxt;
   logic uhigh_r;
   logic uhigh_nxt;
   logic tsd_r;
   logic tsd_nxt;
   logic twarn_r;
   logic twarn_nxt;
   logic rns_r;
   logic rns_nxt;
   logic cpol_r;
   logic cpol_nxt;
   logic link_clear_r;
   logic link_clear_nxt;
   logic [7:0] snap_r;
   logic [7:0] snap_nxt;
   logic [dsf_pkg::NUM_CTRL-1:0][7:0] ctrl_r;
   logic [dsf_pkg::NUM_CTRL-1:0][7:0] ctrl_nxt;
   logic sdo_r;
   logic sdo_nxt;
   logic sdo_oe_r;
   logic sdo_oe_nxt;
   logic gef_r;
   logic gef_nxt;

   logic fault_summary_bit;
   logic load_ev;
   logic [7:0] status_byte;
   logic frame_end;
   logic cnt_err;
   logic frm_err;
   logic do_write;
   logic clr_stat;
   logic [7:0] addr;
   logic [dsf_pkg::CNT_W-1:0] cnt;
   dsf_pkg::dsf_kind_t kind;

   always_comb
   begin
      load_ev = |(open_s | over_s);
      fault_summary_bit = proto_r | load_r | ulow_r | uhigh_r | ~rns_r | tsd_r | twarn_r;
      status_byte = dsf_pkg::BYTE_RST;
      status_byte[dsf_pkg::PROTO_POS] = proto_r;
      status_byte[dsf_pkg::LOAD_POS] = load_r;
      status_byte[dsf_pkg::SUPPLY_LOW_POS] = ulow_r;
      status_byte[dsf_pkg::SUPPLY_HIGH_POS] = uhigh_r;
      status_byte[dsf_pkg::RESET_SEEN_POS] = rns_r;
      status_byte[dsf_pkg::THERM_SD_POS] = tsd_r;
      status_byte[dsf_pkg::THERM_WARN_POS] = twarn_r;

      cnt = lif.bit_cnt;
      addr = lif.addr_byte;
      kind = dsf_pkg::reg_kind(addr[dsf_pkg::ADDR_MSB:dsf_pkg::ADDR_LSB]);
      // Act only at chip select rise
      frame_end = (state_r == ST_FRAME) && csn_s;
      cnt_err = (cnt != dsf_pkg::CNT_RST)
                && ((cnt[2:0] != 3'h0) || (cnt < dsf_pkg::MIN_FRAME_BITS));
      frm_err = cnt_err
                // Marker missing in last chain byte
                | ((cnt != dsf_pkg::CNT_RST) && !lif.addr_seen)
                | (lif.addr_seen && !addr[dsf_pkg::ONE_POS])
                | (lif.addr_seen && (kind == dsf_pkg::KIND_NONE))
                // Clock high at either chip select edge
                | cpol_r | sclk_s;
      do_write = frame_end && !frm_err && lif.addr_seen && addr[dsf_pkg::OP_POS];
      clr_stat = do_write && (kind == dsf_pkg::KIND_STAT);
   end

   // Sticky status flags
   always_comb
   begin
      // Hardware set wins over a clear in the same cycle
      load_nxt = (load_r & ~clr_stat) | load_ev;
      ulow_nxt = (ulow_r & ~clr_stat) | supply_low_s;
      uhigh_nxt = (uhigh_r & ~clr_stat) | supply_high_s;
      tsd_nxt = (tsd_r & ~clr_stat) | thermal_sd_s;
      twarn_nxt = (twarn_r & ~clr_stat) | thermal_warn_s;
      proto_nxt = (proto_r & ~clr_stat) | (frame_end && frm_err);
      // Cleared status marks reset as seen
      rns_nxt = rns_r | clr_stat;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         proto_r <= dsf_pkg::FLAG_RST;
         load_r <= dsf_pkg::FLAG_RST;
         ulow_r <= dsf_pkg::FLAG_RST;
         uhigh_r <= dsf_pkg::FLAG_RST;
         tsd_r <= dsf_pkg::FLAG_RST;
         twarn_r <= dsf_pkg::FLAG_RST;
         rns_r <= dsf_pkg::RESET_SEEN_RST;
      end
      else
      begin
         proto_r <= proto_nxt;
         load_r <= load_nxt;
         ulow_r <= ulow_nxt;
         uhigh_r <= uhigh_nxt;
         tsd_r <= tsd_nxt;
         twarn_r <= twarn_nxt;
         rns_r <= rns_nxt;
      end
   end

   // Frame state and register store
   always_comb
   begin
      state_nxt = state_r;
      cpol_nxt = cpol_r;
      link_clear_nxt = link_clear_r;
      snap_nxt = snap_r;
      ctrl_nxt = ctrl_r;
      unique case (state_r)
         ST_IDLE:
         begin
            if (!csn_s)
            begin
               state_nxt = ST_FRAME;
               link_clear_nxt = 1'b0;
               snap_nxt = status_byte;
               // Clock level at falling chip select
               cpol_nxt = sclk_s;
            end
         end
         ST_FRAME:
         begin
            if (csn_s)
            begin
               state_nxt = ST_IDLE;
               link_clear_nxt = 1'b1;
               cpol_nxt = 1'b0;
               if (do_write && (kind == dsf_pkg::KIND_CTRL))
                  ctrl_nxt[addr[dsf_pkg::ADDR_LSB+1:dsf_pkg::ADDR_LSB]] = lif.data_byte;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         state_r <= ST_IDLE;
         cpol_r <= 1'b0;
         link_clear_r <= 1'b1;
         snap_r <= dsf_pkg::BYTE_RST;
         ctrl_r <= {dsf_pkg::NUM_CTRL{dsf_pkg::CTRL_RST}};
      end
      else
      begin
         state_r <= state_nxt;
         cpol_r <= cpol_nxt;
         link_clear_r <= link_clear_nxt;
         snap_r <= snap_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end

   // Serial output and summary pins
   always_comb
   begin
      // Summary ORed with input before first rise
      sdo_nxt = 1'b0;
      if (state_nxt == ST_FRAME)
         sdo_nxt = started_s ? out_bit_s : (fault_summary_bit | sdi_s);
      // Output released at chip select rise
      sdo_oe_nxt = (state_nxt == ST_FRAME);
      gef_nxt = fault_summary_bit;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         sdo_r <= 1'b0;
         sdo_oe_r <= 1'b0;
         gef_r <= 1'b1;
      end
      else
      begin
         sdo_r <= sdo_nxt;
         sdo_oe_r <= sdo_oe_nxt;
         gef_r <= gef_nxt;
      end
   end

   // Snapshot and control image stay still for the whole frame
   assign lif.link_clear = link_clear_r;
   assign lif.status_snap = snap_r;
   assign lif.ctrl_img = ctrl_r;

   assign sdo = sdo_r;
   assign sdo_oe = sdo_oe_r;
   assign fault_summary = gef_r;
   assign ctrl_out = ctrl_r;
endmodule
